// *** rtl/display_hw_reset_sequencer.sv ***
// Hardware reset sequencer of a display controller: pin filtering, blanking,
// settings reload and the command hold-off after release.
// Assumes the reset pin is asynchronous and all other inputs are on CLOCK.
module display_hw_reset_sequencer #(
    parameter int CANCEL_SLEEP_IN_CYCLES  = rst_seq_pkg::CANCEL_SLEEP_IN_CYCLES,
    parameter int CANCEL_SLEEP_OUT_CYCLES = rst_seq_pkg::CANCEL_SLEEP_OUT_CYCLES,
    parameter int SLEEP_EXIT_CYCLES       = rst_seq_pkg::SLEEP_EXIT_CYCLES
) (
    input  wire logic CLOCK,
    input  wire logic RST,
    input  wire logic HW_RESET_PIN_N,
    input  wire logic SLEEP_OUT_MODE,
    input  wire logic CMD_VALID,
    input  wire logic CMD_IS_SLEEP_EXIT,
    output logic      CMD_ACCEPT,
    output logic      RESET_ACTIVE,
    output logic      REGS_DEFAULT,
    output logic      DISPLAY_BLANK,
    output logic      NVM_LOAD_START
);
    localparam int IW = rst_seq_pkg::INTERVAL_W;
    localparam int RW = rst_seq_pkg::RUN_W;
    // Pin edges reach pin_s2 two clocks late; the limits give that time back
    localparam int LAG = 2;

    typedef enum logic [1:0] {RUN, HOLD, CANCEL} state_t;

    logic          pin_s1;
    logic          pin_s2;
    logic          filt_n;
    state_t        state;
    state_t        next_state;
    logic          sleep_out;
    logic          next_sleep_out;
    logic [IW-1:0] since_release;
    logic [IW-1:0] next_since_release;
    logic          load_start;
    logic          next_load_start;
    logic [IW-1:0] cancel_limit;
    logic          exit_open;

    // Two flops before the filter; the pin is not on CLOCK
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end
        else
        begin
            pin_s1 <= HW_RESET_PIN_N;
            pin_s2 <= pin_s1;
        end
    end

    pin_spike_filter #(
        .ASSERT_CYCLES  (rst_seq_pkg::ASSERT_CYCLES),
        .RELEASE_CYCLES (rst_seq_pkg::RELEASE_CYCLES),
        .W              (rst_seq_pkg::FILTER_W)
    ) u_filter (
        .clock      (CLOCK),
        .rst        (RST),
        .pin_n      (pin_s2),
        .filtered_n (filt_n)
    );

    // Counts start at the synchronised pin rise, so both limits are short by LAG
    assign cancel_limit = sleep_out ? IW'(CANCEL_SLEEP_OUT_CYCLES - 1 - LAG)
                                    : IW'(CANCEL_SLEEP_IN_CYCLES - 1 - LAG);
    assign exit_open    = (since_release >= IW'(SLEEP_EXIT_CYCLES - LAG));

    // Power-up is treated as a release from sleep-in, so settings load then too
    always_comb
    begin
        next_state         = state;
        next_sleep_out     = sleep_out;
        next_load_start    = 1'b0;
        next_since_release = since_release;
        if (since_release != {IW{1'b1}})
        begin
            next_since_release = since_release + IW'(1);
        end
        case (state)
            RUN:
            begin
                if (!filt_n)
                begin
                    next_state     = HOLD;
                    next_sleep_out = SLEEP_OUT_MODE;
                end
            end
            HOLD:
            begin
                // Timed from the last low sample, so filter delay is not charged to the host
                if (!pin_s2)
                begin
                    next_since_release = '0;
                end
                if (filt_n)
                begin
                    next_state      = CANCEL;
                    next_load_start = 1'b1;
                end
            end
            default:
            begin
                if (!filt_n)
                begin
                    next_state = HOLD;
                end
                else if (since_release >= cancel_limit)
                begin
                    next_state     = RUN;
                    next_sleep_out = rst_seq_pkg::SLEEP_OUT_RESET;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            state         <= CANCEL;
            sleep_out     <= rst_seq_pkg::SLEEP_OUT_RESET;
            since_release <= '0;
            load_start    <= 1'b1;
        end
        else
        begin
            state         <= next_state;
            sleep_out     <= next_sleep_out;
            since_release <= next_since_release;
            load_start    <= next_load_start;
        end
    end

    // Sleep-exit gate protects the panel if the host ignores its hold-off
    assign CMD_ACCEPT     = CMD_VALID && (state == RUN)
                            && (!CMD_IS_SLEEP_EXIT || exit_open);
    assign RESET_ACTIVE   = (state == HOLD);
    assign REGS_DEFAULT   = (state != RUN);
    assign DISPLAY_BLANK  = (state != RUN);
    assign NVM_LOAD_START = load_start;

    // Helper run lengths of the synchronised pin, for checking only
    logic [RW-1:0] low_run;
    logic [RW-1:0] high_run;
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            low_run  <= '0;
            high_run <= '0;
        end
        else
        begin
            low_run  <= pin_s2 ? '0 : ((&low_run) ? low_run : low_run + RW'(1));
            high_run <= !pin_s2 ? '0 : ((&high_run) ? high_run : high_run + RW'(1));
        end
    end

    a_spike_reject: assert property (@(posedge CLOCK) disable iff (RST)
        $fell(filt_n) |-> (low_run >= RW'(rst_seq_pkg::REJECT_CYCLES)))
        else $error("reset taken from a pulse shorter than the reject time");
    a_long_pulse_reset: assert property (@(posedge CLOCK) disable iff (RST)
        (low_run >= RW'(rst_seq_pkg::FULL_RESET_CYCLES)) |-> (state == HOLD))
        else $error("long low pulse did not reset");
    a_glitch_hold: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(filt_n) |-> (high_run >= RW'(rst_seq_pkg::RELEASE_CYCLES)))
        else $error("reset ended by a short high glitch");
    a_reload_on_release: assert property (@(posedge CLOCK) disable iff (RST)
        (state == HOLD && filt_n) |=> (NVM_LOAD_START && state == CANCEL) ##1 !NVM_LOAD_START)
        else $error("settings reload not started on release");
    a_cancel_bound: assert property (@(posedge CLOCK) disable iff (RST)
        (state == CANCEL) |-> (since_release <= cancel_limit))
        else $error("cancel interval overran its limit");
    a_blank_hold: assert property (@(posedge CLOCK) disable iff (RST)
        (state == CANCEL && filt_n && since_release == cancel_limit)
        |=> (!DISPLAY_BLANK && !sleep_out))
        else $error("blanking did not end in default state");
    a_cmd_ignored: assert property (@(posedge CLOCK) disable iff (RST)
        (CMD_VALID && (REGS_DEFAULT || RESET_ACTIVE)) |-> !CMD_ACCEPT)
        else $error("command taken during reset");
    a_exit_holdoff: assert property (@(posedge CLOCK) disable iff (RST)
        (CMD_ACCEPT && CMD_IS_SLEEP_EXIT) |-> (since_release >= IW'(SLEEP_EXIT_CYCLES - LAG)))
        else $error("sleep exit taken too early");
    a_sleep_capture: assert property (@(posedge CLOCK) disable iff (RST)
        ($rose(RESET_ACTIVE) && $past(state) == RUN) |-> (sleep_out == $past(SLEEP_OUT_MODE)))
        else $error("sleep mode not captured at reset entry");
    a_load_after_hold: assert property (@(posedge CLOCK) disable iff (RST)
        (NVM_LOAD_START && !$past(RST)) |-> ($past(state) == HOLD))
        else $error("settings reload started outside a release");
    a_pin_low_blank: assert property (@(posedge CLOCK) disable iff (RST)
        (low_run >= RW'(rst_seq_pkg::FULL_RESET_CYCLES))
        |-> (REGS_DEFAULT && DISPLAY_BLANK && !CMD_ACCEPT))
        else $error("registers not held default while the pin is low");
    a_hold_on_low: assert property (@(posedge CLOCK) disable iff (RST)
        (state == HOLD && !filt_n && !pin_s2) |=> (state == HOLD))
        else $error("reset left while the pin was still low");

    // Main scenarios

    c_reset_pulse: cover property (@(posedge CLOCK) disable iff (RST)
        state == HOLD ##1 state == CANCEL);
    c_sleep_out_reset: cover property (@(posedge CLOCK) disable iff (RST)
        $rose(state == HOLD) && SLEEP_OUT_MODE);
    c_spike: cover property (@(posedge CLOCK) disable iff (RST)
        $rose(pin_s2) && low_run > RW'(0) && filt_n);
    c_exit_cmd: cover property (@(posedge CLOCK) disable iff (RST)
        CMD_ACCEPT && CMD_IS_SLEEP_EXIT);
    c_glitch_in_reset: cover property (@(posedge CLOCK) disable iff (RST)
        (state == HOLD) && pin_s2 && (high_run == RW'(100)));
endmodule // display_hw_reset_sequencer

// *** rtl/rst_seq_pkg.sv ***
// Constants shared by the display hardware reset sequencer and its pin filter.
// Assumes a single 100 MHz system clock.
package rst_seq_pkg;
    localparam int CLOCK_HZ            = 100_000_000;
    // Pulse widths on the reset pin, in microseconds
    localparam int REJECT_TIME_US      = 5;
    localparam int FULL_RESET_TIME_US  = 9;
    localparam int ASSERT_TIME_US      = 7;
    localparam int RELEASE_TIME_US     = 5;
    // Cancel intervals and sleep-exit hold-off, in milliseconds
    localparam int CANCEL_SLEEP_IN_MS  = 5;
    localparam int CANCEL_SLEEP_OUT_MS = 120;
    localparam int SLEEP_EXIT_WAIT_MS  = 120;
    // Derived cycle counts; minimum times round up, maximum times round down
    localparam int REJECT_CYCLES       = (REJECT_TIME_US * (CLOCK_HZ / 1000) + 999) / 1000;
    localparam int FULL_RESET_CYCLES   = (FULL_RESET_TIME_US * (CLOCK_HZ / 1000)) / 1000;
    localparam int ASSERT_CYCLES       = (ASSERT_TIME_US * (CLOCK_HZ / 1000) + 999) / 1000;
    localparam int RELEASE_CYCLES      = (RELEASE_TIME_US * (CLOCK_HZ / 1000) + 999) / 1000;
    localparam int CANCEL_SLEEP_IN_CYCLES  = int'(longint'(CANCEL_SLEEP_IN_MS) * CLOCK_HZ / 1000);
    localparam int CANCEL_SLEEP_OUT_CYCLES = int'(longint'(CANCEL_SLEEP_OUT_MS) * CLOCK_HZ / 1000);
    localparam int SLEEP_EXIT_CYCLES   = int'(longint'(SLEEP_EXIT_WAIT_MS) * CLOCK_HZ / 1000);
    // Widths
    localparam int FILTER_W            = 10;
    localparam int RUN_W               = 11;
    localparam int INTERVAL_W          = 24;
    // Reset values
    localparam logic SLEEP_OUT_RESET   = 1'b0;
endpackage

// *** rtl/pin_spike_filter.sv ***
// Debounce filter for the synchronised, active-low reset pin level.
// Assumes its input is already in the CLOCK domain.
module pin_spike_filter #(
    parameter int ASSERT_CYCLES  = rst_seq_pkg::ASSERT_CYCLES,
    parameter int RELEASE_CYCLES = rst_seq_pkg::RELEASE_CYCLES,
    parameter int W              = rst_seq_pkg::FILTER_W
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic pin_n,
    output logic      filtered_n
);
    logic [W-1:0] run;
    logic [W-1:0] next_run;
    logic         next_filtered_n;

    // A level must differ from the filtered state for the full count to flip it
    always_comb
    begin
        next_run        = '0;
        next_filtered_n = filtered_n;
        if (pin_n != filtered_n)
        begin
            next_run = run + W'(1);
            if (filtered_n && (run == W'(ASSERT_CYCLES - 1)))
            begin
                next_filtered_n = 1'b0;
                next_run        = '0;
            end
            else if (!filtered_n && (run == W'(RELEASE_CYCLES - 1)))
            begin
                next_filtered_n = 1'b1;
                next_run        = '0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            run        <= '0;
            filtered_n <= 1'b1;
        end
        else
        begin
            run        <= next_run;
            filtered_n <= next_filtered_n;
        end
    end
endmodule // pin_spike_filter

// *** testbench/host_model.sv ***
// Host controller model: drives the reset pin and offers commands.
// Assumes the device answers CMD_ACCEPT combinationally in the offer cycle.
module host_model #(
    parameter int CMD_WAIT  = 600,
    parameter int EXIT_WAIT = 760
) (
    input  wire logic clock,
    input  wire logic cmd_accept,
    output logic      pin_n,
    output logic      cmd_valid,
    output logic      cmd_is_sleep_exit
);
    timeunit 1ns;
    timeprecision 1ps;
    int since_release = 0;
    initial
    begin
        pin_n = 1'b1;
        cmd_valid = 1'b0;
        cmd_is_sleep_exit = 1'b0;
    end
    // Hold-offs are reckoned from the raw pin rise, as a real host sees it
    always @(posedge clock)
    begin
        if (!pin_n)
            since_release <= 0;
        else if (since_release < 100000)
            since_release <= since_release + 1;
    end
    task automatic pulse(input int low_c, input int glitch_c, input int low2_c);
        @(posedge clock);
        pin_n <= 1'b0;
        repeat (low_c) @(posedge clock);
        if (glitch_c > 0)
        begin
            pin_n <= 1'b1;
            repeat (glitch_c) @(posedge clock);
            pin_n <= 1'b0;
            repeat (low2_c) @(posedge clock);
        end
        pin_n <= 1'b1;
    endtask
    // Callers pass CMD_WAIT or EXIT_WAIT; shorter waits are deliberate misuse
    task automatic send(input logic exit, input int wait_c, output logic acc);
        while (since_release < wait_c) @(posedge clock);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_is_sleep_exit <= exit;
        #1 acc = cmd_accept;
        @(posedge clock);
        cmd_valid <= 1'b0;
        cmd_is_sleep_exit <= ~exit;
    endtask
endmodule // host_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the display hardware reset sequencer.
// Assumes shortened cancel counts; filter thresholds come from the package.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CIN = 600;
    localparam int COUT = 1200;
    localparam int EXIT = 1200;
    localparam int FILT = rst_seq_pkg::RELEASE_CYCLES + 3;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sleep_out = 1'b0;
    logic pin_n, cmd_valid, cmd_exit, cmd_accept, reset_active;
    logic regs_default, display_blank, nvm_start, acc;
    logic ra_d = 1'b0;
    int num_errors = 0;
    int n_checks = 0;
    int nvm_n = 0;
    int ra_n = 0;
    int n0, r0, took;
    initial forever #5 clock = ~clock;
    always @(posedge clock)
    begin
        ra_d <= reset_active;
        if (nvm_start === 1'b1 && !rst) nvm_n <= nvm_n + 1;
        if (reset_active === 1'b1 && ra_d !== 1'b1) ra_n <= ra_n + 1;
    end
    display_hw_reset_sequencer #(.CANCEL_SLEEP_IN_CYCLES(CIN),
        .CANCEL_SLEEP_OUT_CYCLES(COUT), .SLEEP_EXIT_CYCLES(EXIT))
    u_display_hw_reset_sequencer (.CLOCK(clock), .RST(rst), .HW_RESET_PIN_N(pin_n),
        .SLEEP_OUT_MODE(sleep_out), .CMD_VALID(cmd_valid), .CMD_IS_SLEEP_EXIT(cmd_exit),
        .CMD_ACCEPT(cmd_accept), .RESET_ACTIVE(reset_active), .REGS_DEFAULT(regs_default),
        .DISPLAY_BLANK(display_blank), .NVM_LOAD_START(nvm_start));
    host_model #(.CMD_WAIT(CIN), .EXIT_WAIT(EXIT)) u_host_model (.clock(clock),
        .cmd_accept(cmd_accept), .pin_n(pin_n),
        .cmd_valid(cmd_valid), .cmd_is_sleep_exit(cmd_exit));
    task automatic check(input string name, input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic blank_clear_by(input int limit);
        took = 0;
        while (display_blank !== 1'b0 && took < limit)
        begin
            @(posedge clock);
            #1;
            took++;
        end
    endtask
    task automatic t_power_up();
        repeat (4) @(posedge clock);
        #1;
        check("nvm_in_rst", nvm_start, 1'b1);
        check("blank_in_rst", display_blank, 1'b1);
        check("default_in_rst", regs_default, 1'b1);
        @(posedge clock);
        rst <= 1'b0;
        blank_clear_by(CIN + 5);
        check("blank_power_up", display_blank, 1'b0);
        check("default_power_up", regs_default, 1'b0);
    endtask
    task automatic t_spike();
        r0 = ra_n;
        n0 = nvm_n;
        u_host_model.pulse(490, 0, 0);
        repeat (FILT + 100) @(posedge clock);
        #1;
        check("spike_ignored", ra_n == r0, 1'b1);
        check("spike_no_reload", nvm_n == n0, 1'b1);
        check("spike_no_blank", display_blank, 1'b0);
    endtask
    task automatic t_full_reset();
        n0 = nvm_n;
        u_host_model.pulse(920, 0, 0);
        #1;
        check("reset_taken", reset_active, 1'b1);
        check("blank_held", display_blank, 1'b1);
        check("default_held", regs_default, 1'b1);
        u_host_model.send(1'b0, 0, acc);
        check("cmd_in_reset", acc, 1'b0);
        blank_clear_by(CIN + 2);
        check("cancel_done", display_blank, 1'b0);
        check("default_done", regs_default, 1'b0);
        check("reload_once", nvm_n == n0 + 1, 1'b1);
        u_host_model.send(1'b0, u_host_model.CMD_WAIT, acc);
        check("cmd_after", acc, 1'b1);
        u_host_model.send(1'b1, u_host_model.CMD_WAIT + 20, acc);
        check("exit_early", acc, 1'b0);
        u_host_model.send(1'b1, u_host_model.EXIT_WAIT, acc);
        check("exit_late", acc, 1'b1);
    endtask
    task automatic t_glitch();
        n0 = nvm_n;
        r0 = ra_n;
        u_host_model.pulse(1000, 300, 1000);
        #1;
        check("glitch_held", reset_active, 1'b1);
        blank_clear_by(CIN + 2);
        check("glitch_cancel_done", display_blank, 1'b0);
        check("glitch_one_reset", ra_n == r0 + 1, 1'b1);
        check("glitch_one_reload", nvm_n == n0 + 1, 1'b1);
    endtask
    task automatic t_sleep_out();
        @(posedge clock);
        sleep_out <= 1'b1;
        u_host_model.pulse(1000, 0, 0);
        sleep_out <= 1'b0;
        repeat (FILT + CIN + 20) @(posedge clock);
        #1;
        check("blank_sleep_out", display_blank, 1'b1);
        blank_clear_by(COUT - FILT - CIN - 18);
        check("cancel_sleep_out", display_blank, 1'b0);
        check("default_sleep_out", regs_default, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Whole run is about 9k cycles; this limit leaves ample margin
    initial
    begin
        #500000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        t_power_up();
        t_spike();
        t_full_reset();
        t_glitch();
        t_sleep_out();
        tally_and_finish();
    end
endmodule // tb_top
